// [core/cell_pkg.sv]
// shared constants and types for the programmable logic cell
package cell_pkg;

  // ------------------------------------------------------------
  // operating modes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_NORMAL    = 4'h1,
    MODE_ARITH     = 4'h2,
    MODE_UPDOWN    = 4'h4,
    MODE_CLEARABLE = 4'h8
  } cell_mode_type;

  // ------------------------------------------------------------
  // clear / preset configurations
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    CP_CLEAR      = 6'h01,
    CP_PRESET     = 6'h02,
    CP_CLR_PRE    = 6'h04,
    CP_LOAD_CLR   = 6'h08,
    CP_LOAD_PRE   = 6'h10,
    CP_LOAD_ONLY  = 6'h20
  } clr_pre_mode_type;

  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int          MASK_W     = 16;
  localparam int          HALF_W     = 8;
  localparam int          SEL3_W     = 3;
  localparam int          SEL4_W     = 4;
  localparam int          TRI_DRV_N  = 4;
  localparam int          TRI_CNT_W  = 3;
  localparam logic        REG_RST    = 1'b0;
  localparam logic        LVL_HIGH   = 1'b1;
  localparam logic        LVL_LOW    = 1'b0;

  // ------------------------------------------------------------
  // register state of the cell
  // ------------------------------------------------------------
  typedef struct packed {
    logic store;
  } cell_state_type;

endpackage : cell_pkg

// [core/lut_core.sv]
// lookup function: one four-input table, or two three-input halves
module lut_core (
  input  wire logic [cell_pkg::MASK_W-1:0] mask,
  input  wire logic [cell_pkg::SEL4_W-1:0] sel4,
  input  wire logic [cell_pkg::SEL3_W-1:0] sel3,
  output logic                             out4,
  output logic                             out_lo,
  output logic                             out_hi
);

  logic [cell_pkg::HALF_W-1:0] lo_half;
  logic [cell_pkg::HALF_W-1:0] hi_half;

  assign lo_half = mask[cell_pkg::HALF_W-1:0];
  assign hi_half = mask[cell_pkg::MASK_W-1:cell_pkg::HALF_W];

  // split mode shares the three selects; the upper half feeds the carry
  always_comb begin
    out4   = mask[sel4];
    out_lo = lo_half[sel3];
    out_hi = hi_half[sel3];
  end

endmodule : lut_core

// [core/tri_bus_emu.sv]
// internal tri-state bus emulated as a selector
module tri_bus_emu (
  input  wire logic [cell_pkg::TRI_DRV_N-1:0] drv_data,
  input  wire logic [cell_pkg::TRI_DRV_N-1:0] drv_en,
  output logic                                bus_out
);

  logic [cell_pkg::TRI_CNT_W-1:0] n_en;
  logic                           picked;

  // contention resolves low, a floating bus resolves high
  always_comb begin
    n_en   = '0;
    picked = cell_pkg::LVL_LOW;
    for (int i = 0; i < cell_pkg::TRI_DRV_N; i++) begin
      if (drv_en[i]) begin
        n_en   = n_en + 3'h1;
        picked = drv_data[i];
      end
    end
    case (n_en)
      3'h0:    bus_out = cell_pkg::LVL_HIGH;
      3'h1:    bus_out = picked;
      default: bus_out = cell_pkg::LVL_LOW;
    endcase
  end

endmodule : tri_bus_emu

// [core/logic_cell.sv]
// programmable logic cell: lookup function, register, chains, clear/preset
module logic_cell (
  input  wire logic                                sys_clk,
  input  wire logic                                arst_n,
  // configuration
  input  wire cell_pkg::cell_mode_type             cell_mode,
  input  wire cell_pkg::clr_pre_mode_type          clr_pre_mode,
  input  wire logic [cell_pkg::MASK_W-1:0]         lut_mask,
  input  wire logic                                lut_use_carry,
  input  wire logic                                cascade_en,
  input  wire logic                                cascade_or,
  input  wire logic                                pack_en,
  input  wire logic                                pack_from_input_four,
  input  wire logic                                pack_reg_to_routed,
  input  wire logic                                out_from_reg,
  input  wire logic                                ena_from_input_one,
  input  wire logic                                chip_reset_en,
  // fabric inputs
  input  wire logic                                cell_input_one,
  input  wire logic                                cell_input_two,
  input  wire logic                                cell_input_three,
  input  wire logic                                cell_input_four,
  input  wire logic                                cluster_ctl_line_a,
  input  wire logic                                cluster_ctl_line_b,
  input  wire logic                                clk_ena,
  input  wire logic                                chip_reset_n,
  // chains
  input  wire logic                                carry_in,
  input  wire logic                                cascade_in,
  output logic                                     carry_out,
  output logic                                     cascade_out,
  // outputs
  output logic                                     local_out,
  output logic                                     routed_out,
  // emulated internal bus
  input  wire logic [cell_pkg::TRI_DRV_N-1:0]      tri_drv_data,
  input  wire logic [cell_pkg::TRI_DRV_N-1:0]      tri_drv_en,
  output logic                                     tri_bus_out
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  cell_pkg::cell_state_type       state_q;
  cell_pkg::cell_state_type       state_d;

  logic [cell_pkg::SEL4_W-1:0]    sel4;
  logic [cell_pkg::SEL3_W-1:0]    sel3;
  logic                           lut4_out;
  logic                           lut_lo;
  logic                           lut_hi;

  logic                           is_counter;
  logic                           reg_inverted;
  logic                           reg_out;
  logic                           cascaded;
  logic                           comb_out;
  logic                           reg_in;
  logic                           count_next;
  logic                           sync_clear;
  logic                           load_mux;
  logic                           reg_ena;
  logic                           clr_n;
  logic                           pre_n;
  logic                           chip_rst_act;
  logic                           store_eff;

  // ------------------------------------------------------------
  // lookup selects
  // ------------------------------------------------------------
  assign is_counter = (cell_mode == cell_pkg::MODE_UPDOWN) ||
                      (cell_mode == cell_pkg::MODE_CLEARABLE);

  always_comb begin
    // normal: carry-in or input three as the third select
    sel4 = {cell_input_four,
            lut_use_carry ? carry_in : cell_input_three,
            cell_input_two,
            cell_input_one};
    // packed with a three-input function: input four is kept off the table
    if (pack_en && pack_from_input_four) begin
      sel4[cell_pkg::SEL4_W-1] = cell_pkg::LVL_LOW;
    end
    if (is_counter) begin
      // count and carry halves see feedback, direction and carry-in
      sel3 = {carry_in, cell_input_two, reg_out};
    end else begin
      sel3 = {carry_in, cell_input_two, cell_input_one};
    end
  end

  lut_core u_lut (
    .mask   (lut_mask),
    .sel4   (sel4),
    .sel3   (sel3),
    .out4   (lut4_out),
    .out_lo (lut_lo),
    .out_hi (lut_hi)
  );

  // ------------------------------------------------------------
  // cascade and carry chains
  // ------------------------------------------------------------
  // the OR form is AND with inputs and output inverted
  function automatic logic cascade_join(input logic a, input logic b, input logic use_or);
    if (use_or) begin
      cascade_join = ~(~a & ~b);
    end else begin
      cascade_join = a & b;
    end
  endfunction : cascade_join

  always_comb begin
    case (cell_mode)
      cell_pkg::MODE_NORMAL: begin
        cascaded  = cascade_en ? cascade_join(lut4_out, cascade_in, cascade_or)
                               : lut4_out;
        carry_out = cell_pkg::LVL_LOW;
      end
      cell_pkg::MODE_ARITH: begin
        cascaded  = cascade_en ? cascade_join(lut_lo, cascade_in, cascade_or)
                               : lut_lo;
        carry_out = lut_hi;
      end
      cell_pkg::MODE_UPDOWN,
      cell_pkg::MODE_CLEARABLE: begin
        cascaded  = lut_lo;
        carry_out = lut_hi;
      end
      default: begin
        cascaded  = lut4_out;
        carry_out = cell_pkg::LVL_LOW;
      end
    endcase
  end

  assign cascade_out = cascaded;
  assign comb_out    = cascaded;

  // ------------------------------------------------------------
  // register data path
  // ------------------------------------------------------------
  always_comb begin
    count_next = lut_lo;
    // clearable mode takes its synchronous clear from the cascade-in slot
    sync_clear = (cell_mode == cell_pkg::MODE_CLEARABLE) && cascade_in;
    // input four is the active-low load select, input three the load value
    if (!cell_input_four) begin
      load_mux = cell_input_three;
    end else if (cell_input_one) begin
      load_mux = count_next;
    end else begin
      load_mux = reg_out;
    end
    case (cell_mode)
      cell_pkg::MODE_NORMAL: begin
        if (pack_en) begin
          reg_in = pack_from_input_four ? cell_input_four
                                        : cell_input_one;
        end else begin
          reg_in = comb_out;
        end
      end
      cell_pkg::MODE_ARITH:     reg_in = comb_out;
      cell_pkg::MODE_UPDOWN:    reg_in = load_mux;
      cell_pkg::MODE_CLEARABLE: reg_in = load_mux & ~sync_clear;
      default:                  reg_in = comb_out;
    endcase
  end

  // clock enable applies in every mode, packed or not
  assign reg_ena = clk_ena & (ena_from_input_one ? cell_input_one
                                                 : cell_pkg::LVL_HIGH);

  // ------------------------------------------------------------
  // clear and preset steering
  // ------------------------------------------------------------
  // lines are active high here; the resulting strobes are active low
  always_comb begin
    clr_n = cell_pkg::LVL_HIGH;
    pre_n = cell_pkg::LVL_HIGH;
    case (clr_pre_mode)
      cell_pkg::CP_CLEAR: begin
        clr_n = ~(cluster_ctl_line_a | cluster_ctl_line_b);
      end
      cell_pkg::CP_PRESET: begin
        // input three is held high by the fabric, so line a loads a one
        pre_n = ~(cluster_ctl_line_a & cell_input_three);
        clr_n = ~(cluster_ctl_line_a & ~cell_input_three);
      end
      cell_pkg::CP_CLR_PRE: begin
        pre_n = ~(cluster_ctl_line_a & cell_input_three);
        clr_n = ~(cluster_ctl_line_b | (cluster_ctl_line_a & ~cell_input_three));
      end
      cell_pkg::CP_LOAD_CLR: begin
        pre_n = ~(cluster_ctl_line_a & cell_input_three);
        clr_n = ~(cluster_ctl_line_b | (cluster_ctl_line_a & ~cell_input_three));
      end
      cell_pkg::CP_LOAD_PRE: begin
        // stored bit is inverted: clearing it presents a one at the output
        pre_n = ~(cluster_ctl_line_a & cell_input_three);
        clr_n = ~(cluster_ctl_line_b | (cluster_ctl_line_a & ~cell_input_three));
      end
      cell_pkg::CP_LOAD_ONLY: begin
        pre_n = ~(cluster_ctl_line_a & cell_input_three);
        clr_n = ~(cluster_ctl_line_a & ~cell_input_three);
      end
      default: begin
        clr_n = cell_pkg::LVL_HIGH;
        pre_n = cell_pkg::LVL_HIGH;
      end
    endcase
  end

  assign reg_inverted = (clr_pre_mode == cell_pkg::CP_LOAD_PRE);
  assign chip_rst_act = chip_reset_en & ~chip_reset_n;

  // asynchronous controls act on the output at once and are captured
  // on the next edge, so the flop itself only ever resets to a constant
  always_comb begin
    if (chip_rst_act) begin
      store_eff = cell_pkg::REG_RST;
    end else if (!clr_n) begin
      store_eff = cell_pkg::LVL_LOW;
    end else if (!pre_n) begin
      store_eff = cell_pkg::LVL_HIGH;
    end else begin
      store_eff = state_q.store;
    end
  end

  // an inverted register comes out set under chip reset
  assign reg_out = reg_inverted ? ~store_eff : store_eff;

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (chip_rst_act || !clr_n || !pre_n) begin
      state_d.store = store_eff;
    end else if (reg_ena) begin
      state_d.store = reg_inverted ? ~reg_in : reg_in;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q.store <= cell_pkg::REG_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // cell outputs
  // ------------------------------------------------------------
  always_comb begin
    if (pack_en) begin
      // register and lookup serve unrelated functions on the two outputs
      routed_out = pack_reg_to_routed ? reg_out : comb_out;
      local_out  = pack_reg_to_routed ? comb_out : reg_out;
    end else begin
      routed_out = out_from_reg ? reg_out : comb_out;
      local_out  = out_from_reg ? reg_out : comb_out;
    end
  end

  tri_bus_emu u_tri (
    .drv_data (tri_drv_data),
    .drv_en   (tri_drv_en),
    .bus_out  (tri_bus_out)
  );

endmodule : logic_cell

// [bench/cell_properties.sv]
// concurrent checks on the ports of the logic cell
module cell_properties (
  input wire logic                          sys_clk,
  input wire logic                          arst_n,
  input wire cell_pkg::cell_mode_type       cell_mode,
  input wire cell_pkg::clr_pre_mode_type    clr_pre_mode,
  input wire logic [cell_pkg::MASK_W-1:0]   lut_mask,
  input wire logic                          lut_use_carry,
  input wire logic                          cascade_en,
  input wire logic                          cascade_or,
  input wire logic                          pack_en,
  input wire logic                          out_from_reg,
  input wire logic                          ena_from_input_one,
  input wire logic                          chip_reset_en,
  input wire logic                          chip_reset_n,
  input wire logic                          cell_input_one,
  input wire logic                          cell_input_two,
  input wire logic                          cell_input_three,
  input wire logic                          cell_input_four,
  input wire logic                          cluster_ctl_line_a,
  input wire logic                          cluster_ctl_line_b,
  input wire logic                          clk_ena,
  input wire logic                          carry_in,
  input wire logic                          cascade_in,
  input wire logic                          carry_out,
  input wire logic                          cascade_out,
  input wire logic                          local_out,
  input wire logic                          routed_out,
  input wire logic [cell_pkg::TRI_DRV_N-1:0] tri_drv_data,
  input wire logic [cell_pkg::TRI_DRV_N-1:0] tri_drv_en,
  input wire logic                          tri_bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [3:0] norm_idx;
  logic       norm_lk;
  logic       norm_casc;
  logic       quiet;
  assign norm_idx = {cell_input_four, (lut_use_carry ? carry_in : cell_input_three),
                     cell_input_two, cell_input_one};
  assign norm_lk  = lut_mask[norm_idx];
  // the cascade join sits ahead of both cell outputs, not only cascade-out
  assign norm_casc = !cascade_en ? norm_lk
                                 : (cascade_or ? (norm_lk | cascade_in) : (norm_lk & cascade_in));
  // register visible on both outputs, no async control pending
  assign quiet = out_from_reg && !pack_en && !cluster_ctl_line_a && !cluster_ctl_line_b
                 && !(chip_reset_en && !chip_reset_n);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_tri_float_high: assert property (tri_drv_en == 4'h0 |-> tri_bus_out)
    else $error("floating bus not high");
  a_tri_contend_low: assert property (!$onehot0(tri_drv_en) |-> !tri_bus_out)
    else $error("contended bus not low");
  a_tri_single_drive: assert property ($onehot(tri_drv_en) |-> tri_bus_out == |(tri_drv_en & tri_drv_data))
    else $error("single driver not passed");
  a_arith_carry_half: assert property (cell_mode == cell_pkg::MODE_ARITH |->
    carry_out == lut_mask[{1'b1, carry_in, cell_input_two, cell_input_one}])
    else $error("arithmetic carry wrong");
  a_normal_lookup_both: assert property (cell_mode == cell_pkg::MODE_NORMAL && !pack_en && !out_from_reg |->
    local_out == norm_casc && routed_out == local_out)
    else $error("normal lookup output wrong");
  a_cascade_and_combine: assert property (cell_mode == cell_pkg::MODE_NORMAL && !pack_en && cascade_en && !cascade_or |->
    cascade_out == (lut_mask[norm_idx] & cascade_in))
    else $error("cascade combine wrong");
  a_cascade_or_combine: assert property (cell_mode == cell_pkg::MODE_NORMAL && !pack_en && cascade_en && cascade_or |->
    cascade_out == (lut_mask[norm_idx] | cascade_in))
    else $error("cascade or combine wrong");
  a_clear_either_line: assert property (clr_pre_mode == cell_pkg::CP_CLEAR && out_from_reg && !pack_en &&
    (cluster_ctl_line_a || cluster_ctl_line_b) |-> !local_out && !routed_out)
    else $error("async clear not seen");
  a_enable_hold_value: assert property ((!clk_ena && quiet) ##1 (quiet && $stable(clr_pre_mode)) |->
    $stable(local_out))
    else $error("register moved without enable");
  a_sync_clear_count: assert property ((cell_mode == cell_pkg::MODE_CLEARABLE && cascade_in && clk_ena &&
    !ena_from_input_one && quiet && clr_pre_mode == cell_pkg::CP_CLEAR) ##1
    (quiet && clr_pre_mode == cell_pkg::CP_CLEAR) |-> !local_out)
    else $error("synchronous clear missed");
endmodule : cell_properties

bind logic_cell cell_properties u_cell_props (.*);

// [bench/cell_neighbour.sv]
// lower-order neighbour cell feeding the carry and cascade chains
module cell_neighbour (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic step,
  output logic      carry_in,
  output logic      cascade_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
    end else if (step) begin
      cnt_q <= cnt_q + 4'h3;
    end
  end
  // odd stride visits every state, so both chain lines toggle often
  assign carry_in   = cnt_q[3] ^ cnt_q[0];
  assign cascade_in = cnt_q[1];
endmodule : cell_neighbour

// [bench/logic_cell_tb_top.sv]
// self-checking bench for the programmable logic cell
module logic_cell_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, lut_use_carry, cascade_en, cascade_or, pack_en, step;
  logic pack_from_input_four, pack_reg_to_routed, out_from_reg, ena_from_input_one;
  logic chip_reset_en, chip_reset_n, cell_input_one, cell_input_two, cell_input_three;
  logic cell_input_four, cluster_ctl_line_a, cluster_ctl_line_b, clk_ena, carry_in;
  logic cascade_in, carry_out, cascade_out, local_out, routed_out, tri_bus_out;
  logic [cell_pkg::TRI_DRV_N-1:0] tri_drv_data, tri_drv_en;
  logic [cell_pkg::MASK_W-1:0]    lut_mask;
  cell_pkg::cell_mode_type        cell_mode;
  cell_pkg::clr_pre_mode_type     clr_pre_mode;
  logic [31:0]                    r, r2;
  logic [2:0]                     sel;
  logic [1:0]                     pair;
  logic                           q_exp, q_nx, comb, c3, enabled;
  int                             n_fail, cmp_count;
  // async rows: mode and {chip reset, line a, line b, input three, expected}
  cell_pkg::clr_pre_mode_type cp_tab [12] = '{cell_pkg::CP_CLEAR, cell_pkg::CP_CLEAR,
    cell_pkg::CP_PRESET, cell_pkg::CP_CLR_PRE, cell_pkg::CP_CLR_PRE, cell_pkg::CP_LOAD_CLR,
    cell_pkg::CP_LOAD_CLR, cell_pkg::CP_LOAD_ONLY, cell_pkg::CP_LOAD_ONLY,
    cell_pkg::CP_LOAD_PRE, cell_pkg::CP_LOAD_PRE, cell_pkg::CP_CLR_PRE};
  logic [4:0] bit_tab [12] = '{5'h08, 5'h06, 5'h0B, 5'h06, 5'h0B, 5'h06, 5'h0B, 5'h08,
    5'h0B, 5'h0A, 5'h05, 5'h1A};

  logic_cell uut (.*);
  cell_neighbour partner (.*);

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic tri_exp(input logic [3:0] en, input logic [3:0] d);
    if (en == 4'h0) return 1'b1;
    if ($onehot(en)) return |(en & d);
    return 1'b0;
  endfunction : tri_exp

  // cascade join: AND, or OR by inverting inputs and output
  function automatic logic casc_exp(input logic lk, input logic ci,
                                    input logic en, input logic use_or);
    if (!en) return lk;
    return use_or ? (lk | ci) : (lk & ci);
  endfunction : casc_exp

  task automatic chk(input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {arst_n, lut_use_carry, cascade_or, pack_en, step, pack_from_input_four} = '0;
    {pack_reg_to_routed, ena_from_input_one, cell_input_one, cell_input_two} = '0;
    {cell_input_three, cell_input_four, cluster_ctl_line_a, cluster_ctl_line_b} = '0;
    {clk_ena, tri_drv_data, tri_drv_en, lut_mask} = '0;
    {cascade_en, out_from_reg, chip_reset_en, chip_reset_n} = 4'hF;
    cell_mode = cell_pkg::MODE_NORMAL;
    clr_pre_mode = cell_pkg::CP_CLEAR;
    n_fail = 0;
    cmp_count = 0;
    r = 32'h000142DE;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    // async controls act at once and are held once released
    for (int i = 0; i < 12; i++) begin
      @(posedge sys_clk);
      clr_pre_mode <= cp_tab[i];
      {cluster_ctl_line_a, cluster_ctl_line_b, cell_input_three} <= bit_tab[i][3:1];
      chip_reset_n <= !bit_tab[i][4];
      @(negedge sys_clk);
      chk({3'h0, bit_tab[i][0]}, {3'h0, local_out});
      @(posedge sys_clk);
      {cluster_ctl_line_a, cluster_ctl_line_b, chip_reset_n} <= 3'h1;
      @(negedge sys_clk);
      chk({3'h0, bit_tab[i][0]}, {3'h0, routed_out});
    end
    q_nx = 1'b0;
    // first half: lookup modes; second half: counter modes
    for (int i = 0; i < 128; i++) begin
      r = lfsr(r);
      r2 = r;
      r = lfsr(r);
      @(posedge sys_clk);
      q_exp = q_nx;
      clr_pre_mode <= cell_pkg::CP_CLEAR;
      lut_mask <= r[15:0];
      {cell_input_four, cell_input_three, cell_input_two, cell_input_one} <= r[19:16];
      tri_drv_en <= r[23:20];
      tri_drv_data <= r[27:24];
      {step, ena_from_input_one, lut_use_carry, pack_from_input_four} <= r[31:28];
      pack_reg_to_routed <= r2[0];
      {cascade_en, cascade_or} <= r2[5:4];
      if (i < 64) begin
        cell_mode <= r2[1] ? cell_pkg::MODE_ARITH : cell_pkg::MODE_NORMAL;
        pack_en <= !r2[1] && r2[2];
        out_from_reg <= 1'b0;
        clk_ena <= !r2[1] && r2[2] && r2[3];
      end else begin
        cell_mode <= r2[1] ? cell_pkg::MODE_CLEARABLE : cell_pkg::MODE_UPDOWN;
        pack_en <= 1'b0;
        out_from_reg <= 1'b1;
        clk_ena <= r2[3];
      end
      @(negedge sys_clk);
      enabled = clk_ena && (!ena_from_input_one || cell_input_one);
      sel = {carry_in, cell_input_two, cell_input_one};
      c3 = lut_use_carry ? carry_in : cell_input_three;
      if (cell_mode == cell_pkg::MODE_ARITH) begin
        comb = casc_exp(lut_mask[{1'b0, sel}], cascade_in, cascade_en, cascade_or);
        chk({comb, comb, lut_mask[{1'b1, sel}], comb}, {local_out, routed_out, carry_out, cascade_out});
      end else if (cell_mode == cell_pkg::MODE_NORMAL) begin
        comb = lut_mask[{cell_input_four & !(pack_en & pack_from_input_four), c3,
                         cell_input_two, cell_input_one}];
        comb = casc_exp(comb, cascade_in, cascade_en, cascade_or);
        pair = !pack_en ? {comb, comb} : (pack_reg_to_routed ? {comb, q_exp} : {q_exp, comb});
        chk({pair, comb, 1'b0}, {local_out, routed_out, cascade_out, carry_out});
        if (enabled) q_nx = pack_from_input_four ? cell_input_four : cell_input_one;
      end else begin
        comb = lut_mask[{1'b1, carry_in, cell_input_two, q_exp}];
        chk({q_exp, q_exp, comb, 1'b0}, {local_out, routed_out, carry_out, 1'b0});
        if (enabled) begin
          q_nx = !cell_input_four ? cell_input_three :
                 (cell_input_one ? lut_mask[{1'b0, carry_in, cell_input_two, q_exp}] : q_exp);
          if (cell_mode == cell_pkg::MODE_CLEARABLE && cascade_in) q_nx = 1'b0;
        end
      end
      chk({3'h0, tri_exp(tri_drv_en, tri_drv_data)}, {3'h0, tri_bus_out});
    end
    test_done();
  end
endmodule : logic_cell_tb_top
